// [msled_ctrl.sv]
/*
  start-up mode selector and status indicator controller for a bus logger.
  assumes all inputs are synchronous to core_clk and that the firmware-side
  agents report config read/write results and activity as one-cycle strobes.
*/
// Overview of operation
// - USB present at start picks host storage
// - host storage mode gives card to host
// - booting shows green only
// - host mode green on, red flashes on access
// - card fault: yellow, red on, green off
// - logging mode refuses USB storage access
// - later USB attach enables serial monitor
// - logging reads config, loads if valid
// - invalid config: write default, then load
// - default written: red flashes three times
// - valid config: yellow flashes three times
// - autobaud: yellow steady until rate found
// - loaded config enables bus logging
// - yellow pulses follow bus traffic
// - red flashes on card writes
`timescale 1ns/1ps
`default_nettype none
module msled_ctrl
  import msled_pkg::*;
#(
  parameter int unsigned FLASH_CYC = MSLED_FLASH_CYC, // flash half period
  parameter int unsigned PULSE_CYC = MSLED_PULSE_CYC, // activity blink
  parameter int unsigned BOOT_CYC = MSLED_BOOT_CYC // boot settle time
)(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic usb_present, // usb host cable sensed
  input wire logic boot_done, // boot finished level
  input wire logic card_fault, // memory card error level
  input wire logic host_access, // host read/write strobe
  input wire logic cfg_done, // config read finished strobe
  input wire logic cfg_valid, // qualifies cfg_done
  input wire logic dflt_done, // default config written strobe
  input wire logic autobaud_cfg, // config asks for rate detection
  input wire logic rate_found, // valid bit rate detected
  input wire logic bus_traffic, // bus frame observed strobe
  input wire logic card_write, // log data written strobe
  output logic host_storage_mode, // latched mode
  output logic card_to_host, // card granted to host
  output logic usb_storage_en, // usb storage function enabled
  output logic serial_en, // serial monitor enabled
  output logic cfg_read_req, // read config file
  output logic cfg_write_req, // write default config
  output logic cfg_load, // load the configuration
  output logic bus_enable, // talk to and record the bus
  output logic led_green,
  output logic led_yellow,
  output logic led_red
);
  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (FLASH_CYC < 2 || PULSE_CYC < 2 || BOOT_CYC < 1)
  begin : g_param_check
    $error("msled_ctrl: counts too small");
  end

  // ----------------------------------------------------------------
  // state and counters
  // ----------------------------------------------------------------
  msled_state_t state; // controller state
  msled_state_t next_state;
  logic [31:0] div; // flash divider
  logic flash_tick; // half period elapsed
  logic flash_ph; // square wave phase
  logic [2:0] edges; // toggles done in config flash
  logic dflt_seen; // 1: config flash is red
  logic [31:0] boot_cnt; // boot settle
  logic booted;
  logic traffic_blink; // stretched bus activity
  logic write_blink; // stretched card writes
  logic access_blink; // stretched host access

  // divider gives the flash timebase; no flash rate is given for the part
  assign flash_tick = (div == FLASH_CYC - 1);
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      div <= 32'h0;
    else if (flash_tick)
      div <= 32'h0;
    else
      div <= div + 32'h1;
  end

  // boot settle so usb_present is stable before it is latched
  assign booted = (boot_cnt >= BOOT_CYC) && boot_done;
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      boot_cnt <= 32'h0;
    else if (boot_cnt < BOOT_CYC)
      boot_cnt <= boot_cnt + 32'h1;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic cfg_flash_end; // three flashes done
  assign cfg_flash_end = flash_tick && flash_ph && (edges == 3'(2 * MSLED_CFG_FLASHES - 1));
  always_comb
  begin
    next_state = state;
    case (state)
      MSLED_BOOT:
        if (booted)
          next_state = usb_present ? MSLED_HOST : MSLED_CFG_READ;
      MSLED_CFG_READ:
        if (cfg_done)
          next_state = cfg_valid ? MSLED_CFG_FLASH : MSLED_CFG_WRITE;
      MSLED_CFG_WRITE:
        if (dflt_done)
          next_state = MSLED_CFG_FLASH;
      MSLED_CFG_FLASH:
        if (cfg_flash_end)
          next_state = autobaud_cfg ? MSLED_RATE_DET : MSLED_LOGGING;
      MSLED_RATE_DET:
        if (rate_found)
          next_state = MSLED_LOGGING;
      MSLED_LOGGING: next_state = MSLED_LOGGING;
      MSLED_HOST: next_state = MSLED_HOST;
      MSLED_FAULT: next_state = MSLED_FAULT;
      default: next_state = MSLED_BOOT;
    endcase
    if (card_fault && state != MSLED_BOOT)
      next_state = MSLED_FAULT;
  end

  // state register
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      state <= MSLED_BOOT;
    else
      state <= next_state;
  end

  // mode latched once at the boot exit, never changed until power cycle
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      host_storage_mode <= 1'b0;
    else if (state == MSLED_BOOT && booted)
      host_storage_mode <= usb_present;
  end

  // config flash bookkeeping; phase only runs while flashing
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      flash_ph <= 1'b0;
      edges <= 3'h0;
      dflt_seen <= 1'b0;
    end
    else
    begin
      if (state == MSLED_CFG_WRITE)
        dflt_seen <= 1'b1;
      if (state != MSLED_CFG_FLASH)
      begin
        flash_ph <= 1'b0;
        edges <= 3'h0;
      end
      else if (flash_tick)
      begin
        flash_ph <= ~flash_ph;
        edges <= edges + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // activity stretchers
  // ----------------------------------------------------------------
  wire logic in_log = (state == MSLED_LOGGING);
  wire logic in_host = (state == MSLED_HOST);
  msled_pulse #(.LEN(PULSE_CYC)) u_traffic (
    .core_clk(core_clk), .resetn(resetn),
    .event_in(bus_traffic && in_log), .blink(traffic_blink));
  msled_pulse #(.LEN(PULSE_CYC)) u_write (
    .core_clk(core_clk), .resetn(resetn),
    .event_in(card_write && in_log), .blink(write_blink));
  msled_pulse #(.LEN(PULSE_CYC)) u_access (
    .core_clk(core_clk), .resetn(resetn),
    .event_in(host_access && in_host), .blink(access_blink));

  // ----------------------------------------------------------------
  // output decode
  // ----------------------------------------------------------------
  wire logic in_fault = (state == MSLED_FAULT);
  wire logic in_flash = (state == MSLED_CFG_FLASH);
  wire logic nx_green = !in_fault;
  wire logic nx_yellow = in_fault || (state == MSLED_RATE_DET)
    || (in_flash && !dflt_seen && flash_ph)
    || (in_log && traffic_blink);
  wire logic nx_red = in_fault
    || (in_flash && dflt_seen && flash_ph)
    || (in_log && write_blink)
    || (in_host && access_blink);
  wire logic nx_host_grant = in_host;
  // the logger never hands storage to usb; a late cable gets the serial port
  wire logic nx_serial = host_storage_mode == 1'b0 && usb_present
    && (state != MSLED_BOOT) && !in_host;
  wire logic nx_load = (in_flash || state == MSLED_RATE_DET || in_log);
  wire logic nx_bus = (state == MSLED_RATE_DET) || in_log;

  // registered outputs
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      led_green <= 1'b0;
      led_yellow <= 1'b0;
      led_red <= 1'b0;
      card_to_host <= 1'b0;
      usb_storage_en <= 1'b0;
      serial_en <= 1'b0;
      cfg_read_req <= 1'b0;
      cfg_write_req <= 1'b0;
      cfg_load <= 1'b0;
      bus_enable <= 1'b0;
    end
    else
    begin
      led_green <= nx_green;
      led_yellow <= nx_yellow;
      led_red <= nx_red;
      card_to_host <= nx_host_grant;
      usb_storage_en <= nx_host_grant;
      serial_en <= nx_serial;
      cfg_read_req <= (state == MSLED_CFG_READ);
      cfg_write_req <= (state == MSLED_CFG_WRITE);
      cfg_load <= nx_load;
      bus_enable <= nx_bus;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_boot_leds: assert property (@(posedge core_clk) disable iff (!resetn)
    $past(state) == MSLED_BOOT && $past(resetn) |-> led_green && !led_yellow && !led_red)
    else $error("boot leds wrong");
  a_fault_leds: assert property (@(posedge core_clk) disable iff (!resetn)
    $past(in_fault) |-> !led_green && led_yellow && led_red)
    else $error("fault leds wrong");
  a_mode_pick: assert property (@(posedge core_clk) disable iff (!resetn)
    state == MSLED_BOOT && booted && !card_fault |=> (in_host == $past(usb_present)))
    else $error("mode choice wrong");
  a_mode_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    state != MSLED_BOOT && $past(state) != MSLED_BOOT |-> $stable(host_storage_mode))
    else $error("mode changed");
  a_no_usb_log: assert property (@(posedge core_clk) disable iff (!resetn)
    $past(in_log) |-> !usb_storage_en && !card_to_host)
    else $error("storage open while logging");
  a_host_grant: assert property (@(posedge core_clk) disable iff (!resetn)
    $past(in_host) |-> card_to_host && !serial_en)
    else $error("card not granted to host");
  a_rate_yel: assert property (@(posedge core_clk) disable iff (!resetn)
    $past(state) == MSLED_RATE_DET |-> led_yellow && led_green)
    else $error("rate detect leds wrong");
  a_write_dflt: assert property (@(posedge core_clk) disable iff (!resetn)
    state == MSLED_CFG_READ && cfg_done && !cfg_valid && !card_fault
    |=> state == MSLED_CFG_WRITE ##1 cfg_write_req)
    else $error("default not written");
  a_serial_late: assert property (@(posedge core_clk) disable iff (!resetn)
    in_log && usb_present && $past(in_log) |=> serial_en)
    else $error("serial not enabled");

  // led pictures during the config flash, in host mode and for card writes while logging
  a_red_flash: assert property (@(posedge core_clk) disable iff (!resetn)
    $past(in_flash) && $past(dflt_seen) |-> !led_yellow && led_green)
    else $error("default flash shows yellow");
  a_yel_flash: assert property (@(posedge core_clk) disable iff (!resetn)
    $past(in_flash) && !$past(dflt_seen) |-> !led_red && led_green)
    else $error("config flash shows red");
  a_host_leds: assert property (@(posedge core_clk) disable iff (!resetn)
    $past(in_host) |-> led_green && !led_yellow)
    else $error("host mode leds wrong");
  a_card_log: assert property (@(posedge core_clk) disable iff (!resetn)
    $past(in_log) && $past(write_blink) |-> led_red)
    else $error("card write not shown");
  // the bus is only touched once a configuration has been loaded
  a_bus_loaded: assert property (@(posedge core_clk) disable iff (!resetn)
    bus_enable |-> cfg_load && !host_storage_mode)
    else $error("bus enabled without config");
  a_rate_wait: assert property (@(posedge core_clk) disable iff (!resetn)
    state == MSLED_RATE_DET && !rate_found && !card_fault |=> state == MSLED_RATE_DET)
    else $error("rate detect left early");
  // a card fault is never left until power is cycled
  a_fault_stay: assert property (@(posedge core_clk) disable iff (!resetn)
    in_fault |=> in_fault)
    else $error("fault state left");
  // storage and the serial port never go to usb together
  a_usb_split: assert property (@(posedge core_clk) disable iff (!resetn)
    usb_storage_en |-> host_storage_mode && !serial_en)
    else $error("usb storage and serial together");
endmodule // msled_ctrl
`default_nettype wire

// [msled_pkg.sv]
/*
  package for the start-up mode selector and status indicator block:
  state encodings and timing constants.
  assumes a 50 MHz core clock.
*/
`default_nettype none
package msled_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned MSLED_CLK_HZ = 50000000; // core clock rate
  localparam int unsigned MSLED_FLASH_MS = 100; // half period of a flash
  localparam int unsigned MSLED_FLASH_CYC = MSLED_CLK_HZ / 1000 * MSLED_FLASH_MS;
  localparam int unsigned MSLED_PULSE_US = 2000; // activity blink length
  localparam int unsigned MSLED_PULSE_CYC = MSLED_CLK_HZ / 1000000 * MSLED_PULSE_US;
  localparam int unsigned MSLED_CFG_FLASHES = 3; // flashes after config
  localparam int unsigned MSLED_BOOT_CYC = 16; // boot settle time in cycles
  // ----------------------------------------------------------------
  // controller states, gray along boot, read, write, flash, rate detect, logging
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MSLED_BOOT = 4'h0,
    MSLED_CFG_READ = 4'h1,
    MSLED_CFG_WRITE = 4'h3,
    MSLED_CFG_FLASH = 4'h2,
    MSLED_RATE_DET = 4'h6,
    MSLED_LOGGING = 4'h7,
    MSLED_HOST = 4'h5,
    MSLED_FAULT = 4'h4
  } msled_state_t;
endpackage
`default_nettype wire

// [msled_pulse.sv]
/*
  activity stretcher: turns short event strobes into a visible blink.
  assumes events are synchronous to core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module msled_pulse
  import msled_pkg::*;
#(
  parameter int unsigned LEN = MSLED_PULSE_CYC // blink lasts LEN+1 cycles, then as long dark
)(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic event_in,
  output logic blink
);
  // ----------------------------------------------------------------
  // stretcher
  // ----------------------------------------------------------------
  if (LEN < 2)
  begin : g_len_check
    $error("msled_pulse: LEN too small");
  end
  logic [31:0] cnt; // remaining on/off time
  logic phase; // 1 during the lit part
  // after a lit stretch an equal dark stretch follows, so a busy bus gives a
  // 50 percent duty and a quiet one rare short blinks: brightness follows load
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt <= 32'h0;
      phase <= 1'b0;
      blink <= 1'b0;
    end
    else if (cnt != 32'h0)
      cnt <= cnt - 32'h1;
    else if (phase)
    begin
      phase <= 1'b0;
      blink <= 1'b0;
      cnt <= LEN;
    end
    else if (event_in)
    begin
      phase <= 1'b1;
      blink <= 1'b1;
      cnt <= LEN;
    end
  end
endmodule // msled_pulse
`default_nettype wire

// [msled_far.sv]
/*
  far-side model: config agent, card, usb host and bus traffic.
  assumes the controller's request outputs are levels of its state.
*/
`timescale 1ns/1ps
`default_nettype none
module msled_far
  import msled_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic cfg_read_req,
  input wire logic cfg_write_req,
  input wire logic bus_enable,
  input wire logic card_to_host,
  input wire logic good_cfg, // bench: config file is valid
  input wire logic act_on, // bench: make host and bus activity
  output logic cfg_done,
  output logic cfg_valid,
  output logic dflt_done,
  output logic rate_found,
  output logic host_access,
  output logic bus_traffic,
  output logic card_write
);
  // ----------------------------------------------------------------
  // request timers
  // ----------------------------------------------------------------
  logic [7:0] rd_cnt, wr_cnt, bus_cnt, act_cnt; // ages of requests, and a free-running activity beat counter
  wire logic tick; // activity beat, one in sixteen cycles
  // read and write timers restart whenever their request drops; the bus timer holds
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      {rd_cnt, wr_cnt, bus_cnt, act_cnt} <= '0;
    end
    else
    begin
      rd_cnt <= cfg_read_req ? rd_cnt + 8'h01 : 8'h00;
      wr_cnt <= cfg_write_req ? wr_cnt + 8'h01 : 8'h00;
      bus_cnt <= (bus_enable && bus_cnt != 8'hFF) ? bus_cnt + 8'h01 : bus_cnt;
      act_cnt <= act_cnt + 8'h01;
    end
  end
  // ----------------------------------------------------------------
  // answers
  // ----------------------------------------------------------------
  assign cfg_done = (rd_cnt == 8'h03);
  // qualifier shows the wrong value outside its strobe, no kinder than firmware
  assign cfg_valid = cfg_done ? good_cfg : ~good_cfg;
  assign dflt_done = (wr_cnt == 8'h05);
  assign rate_found = (bus_cnt >= 8'h14); // rate locks 20 cycles into detection
  assign tick = act_on && (act_cnt[3:0] == 4'h0);
  assign host_access = tick && card_to_host;
  assign bus_traffic = tick && bus_enable;
  assign card_write = act_on && bus_enable && (act_cnt[3:0] == 4'h8);
endmodule // msled_far
`default_nettype wire

// [mode_select_status_leds_tb_top.sv]
/*
  self-checking bench for the mode selector and status leds.
  assumes msled_far stands in for firmware, card, host and bus.
*/
`timescale 1ns/1ps
`default_nettype none
module mode_select_status_leds_tb_top
  import msled_pkg::*;
();
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic core_clk, resetn, usb_present, boot_done, card_fault, autobaud_cfg, good_cfg, act_on;
  logic cfg_done, cfg_valid, dflt_done, rate_found, host_access, bus_traffic, card_write;
  logic host_storage_mode, card_to_host, usb_storage_en, serial_en, cfg_read_req;
  logic cfg_write_req, cfg_load, bus_enable, led_green, led_yellow, led_red;
  logic [7:0] c; // counted rises
  int n_fail, n_checks;
  // monitored outputs by bit index, so one task can count any of them
  wire logic [9:0] mon = {cfg_write_req, cfg_read_req, bus_enable, cfg_load, serial_en,
    usb_storage_en, card_to_host, led_red, led_yellow, led_green};
  msled_ctrl #(.FLASH_CYC(8), .PULSE_CYC(4), .BOOT_CYC(16)) i_msled_ctrl (.core_clk, .resetn,
    .usb_present, .boot_done, .card_fault, .host_access, .cfg_done, .cfg_valid, .dflt_done,
    .autobaud_cfg, .rate_found, .bus_traffic, .card_write, .host_storage_mode, .card_to_host,
    .usb_storage_en, .serial_en, .cfg_read_req, .cfg_write_req, .cfg_load, .bus_enable,
    .led_green, .led_yellow, .led_red);
  msled_far i_msled_far (.core_clk, .resetn, .cfg_read_req, .cfg_write_req, .bus_enable,
    .card_to_host, .good_cfg, .act_on, .cfg_done, .cfg_valid, .dflt_done, .rate_found,
    .host_access, .bus_traffic, .card_write);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // sample 1 ns after the edge so its updates have landed
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // bounded wait; running out ends the run as a mismatch
  task automatic wait_hi(input int b);
    int i;
    for (i = 0; i < 300 && mon[b] !== 1'b1; i++) step(1);
    if (mon[b] !== 1'b1)
    begin
      n_fail++;
      give_verdict();
    end
  endtask
  task automatic rises(input int b, input int n);
    logic prev;
    c = 8'h00;
    prev = mon[b];
    repeat (n)
    begin
      step(1);
      if (mon[b] === 1'b1 && prev !== 1'b1) c++;
      prev = mon[b];
    end
  endtask
  // mode is latched, so every scenario begins from a fresh reset
  task automatic start(input logic usb, input logic good, input logic auto);
    @(posedge core_clk);
    resetn <= 1'b0;
    usb_present <= usb;
    good_cfg <= good;
    autobaud_cfg <= auto;
    card_fault <= 1'b0;
    act_on <= 1'b0;
    boot_done <= 1'b0;
    step(20);
    @(posedge core_clk) resetn <= 1'b1;
    // settle time runs out with firmware still busy: no mode may be taken yet
    step(20);
    chk({mon[8], mon[3], mon[2:0]}, 5'h01);
    @(posedge core_clk) boot_done <= 1'b1;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic sc_host();
    start(1'b1, 1'b1, 1'b0);
    wait_hi(3);
    chk({host_storage_mode, usb_storage_en, bus_enable, serial_en}, 4'hC);
    chk(mon[2:0], 3'b001);
    @(posedge core_clk) act_on <= 1'b1;
    rises(2, 64);
    chk({c != 0, led_green}, 2'b11);
    @(posedge core_clk) usb_present <= 1'b0;
    step(10);
    chk({host_storage_mode, card_to_host, serial_en}, 3'b110);
  endtask
  task automatic sc_log();
    start(1'b0, 1'b1, 1'b0);
    wait_hi(8);
    chk({host_storage_mode, usb_storage_en, card_to_host}, 3'b000);
    wait_hi(6);
    rises(1, 60);
    chk(c, MSLED_CFG_FLASHES);
    chk({mon[7], mon[8], mon[9], mon[1]}, 4'h8);
    @(posedge core_clk) act_on <= 1'b1;
    rises(1, 64);
    chk(c != 0, 1'b1);
    rises(2, 64);
    chk(c != 0, 1'b1);
    @(posedge core_clk) act_on <= 1'b0;
    usb_present <= 1'b1;
    step(12);
    chk({serial_en, usb_storage_en, card_to_host, led_yellow}, 4'h8);
  endtask
  task automatic sc_dflt();
    start(1'b0, 1'b0, 1'b1);
    wait_hi(9);
    wait_hi(6);
    chk(mon[9], 1'b0);
    rises(2, 60);
    chk(c, MSLED_CFG_FLASHES);
    chk({mon[2:0], bus_enable}, 4'h7);
    step(30);
    chk(mon[2:0], 3'b001);
    @(posedge core_clk) card_fault <= 1'b1;
    step(3);
    chk(mon[2:0], 3'b110);
    @(posedge core_clk) card_fault <= 1'b0;
    step(5);
    chk(mon[2:0], 3'b110);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    n_fail = 0;
    n_checks = 0;
    resetn = 1'b0;
    {usb_present, card_fault, autobaud_cfg, good_cfg, act_on} = 5'h00;
    boot_done = 1'b0; // firmware readiness is raised by each scenario
    sc_host();
    sc_log();
    sc_dflt();
    give_verdict();
  end
endmodule // mode_select_status_leds_tb_top
`default_nettype wire
